// ==== hw/timer_chan_pkg.sv ====
// Constants, field layouts and carriers for the timer channel control block.
// Assumes a 32-bit APB master and a timer core that consumes the fields.
package timer_chan_pkg;
  localparam logic [7:0] MODE_OFFSET = 8'h1c;
  localparam logic [7:0] ENABLE_OFFSET = 8'h20;
  localparam logic [7:0] CONTROL_OFFSET = 8'h30;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // Mode register: channel 3 at byte 0, channel 4 at byte 1.
  localparam int CH_STRIDE = 8;
  localparam int DIR_LSB = 0;
  localparam int FAST_BIT = 2;
  localparam int PSC_LSB = 2;
  localparam int PRE_BIT = 3;
  localparam int CMP_LSB = 4;
  localparam int FILT_LSB = 4;
  localparam int CLR_BIT = 7;
  // Enable register: four bits per channel from bit 0.
  localparam int EN_STRIDE = 4;
  localparam int EN_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int NEN_BIT = 2;
  localparam int NPOL_BIT = 3;
  // Control register.
  localparam int LOCK_LSB = 0;
  localparam int MOE_BIT = 2;
  localparam int IDLE_OFFSTATE_SEL_BIT = 3;
  localparam int RUN_OFFSTATE_SEL_BIT = 4;
  localparam int IDLE_MAIN_LSB = 8;
  localparam int IDLE_COMPL_LSB = 12;
  localparam logic [1:0] LOCK_POLARITY = 2'd2;
  localparam logic [2:0] PSC_RESET = 3'h0;

  typedef enum logic [1:0] {
    DIR_OUTPUT = 2'b00,
    DIR_IN_OWN = 2'b01,
    DIR_IN_CROSS = 2'b10,
    DIR_IN_TRIG = 2'b11
  } dir_e;

  typedef enum logic [2:0] {
    CMP_FROZEN = 3'b000,
    CMP_SET_ACTIVE = 3'b001,
    CMP_SET_INACTIVE = 3'b010,
    CMP_TOGGLE = 3'b011,
    CMP_FORCE_LOW = 3'b100,
    CMP_FORCE_HIGH = 3'b101,
    CMP_PWM1 = 3'b110,
    CMP_PWM2 = 3'b111
  } cmp_mode_e;

  typedef struct packed {
    logic oc;
    logic oc_en;
    logic ocn;
    logic ocn_en;
  } pin_s;

  typedef struct packed {
    dir_e dir;
    logic ref_clear_en;
    cmp_mode_e compare_mode;
    logic preload_en;
    logic fast_en;
    logic [3:0] input_filter;
    logic [1:0] capture_prescale;
  } chan_cfg_s;
endpackage : timer_chan_pkg

// ==== hw/timer_channel_mode_enable_ctrl.sv ====
// Channel 3 and 4 mode, and channel 1 to 4 enable and polarity control.
// Assumes an APB master on CORE_CLK and pin-side inputs synchronous to it.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Channel 4 direction: output, input4, input3, trigger
// - Channel 3 direction: output, input3, input4, trigger
// - Channel 4 direction writable only when off
// - Channel 3 direction writable only when off
// - Compare fields at documented output-mode positions
// - Filter and prescaler at input-mode positions
// - Complementary polarity: clear high, set low
// - Lock 2/3 blocks complementary polarity on outputs
// - Complementary enable gates complementary output
// - Enable drives compare output to pin
// - Polarity inverts output; locked at level 2/3
// - Input polarity picks rising or falling edge
// - Input enable gates counter capture
// - Four enable bits per channel from bit 0
// - Trigger mapping works only with internal source
// - Compare mode encodes frozen through PWM mode 2
// - Capture prescaler 1/2/4/8, reset on disable
// - Preload flag steers compare value transfer
// - Clear enable drops reference on external trigger
module timer_channel_mode_enable_ctrl
  import timer_chan_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_INPUT_3,
  input wire logic TIMER_INPUT_4,
  input wire logic INTERNAL_TRIGGER_SIG,
  input wire logic TRIGGER_SOURCE_INTERNAL,
  input wire logic FILTERED_EXT_TRIGGER,
  input wire logic [1:0] CH12_IS_INPUT,
  input wire logic [3:0] COMPARE_REFERENCE,
  output pin_s [3:0] PINS,
  output chan_cfg_s [1:0] CH34_CFG,
  output logic [3:0] CAPTURE_EN,
  output logic [1:0] CAPTURE
);
  logic [15:0] mode_reg;
  logic [15:0] enable_reg;
  logic [15:0] control_reg;
  logic [15:0] next_mode;
  logic [15:0] next_enable;
  logic [15:0] rd_word;
  logic [1:0] sel_in;
  logic [1:0] prev_in;
  logic [1:0] edge_hit;
  logic [2:0] psc_count [2];
  logic [3:0] is_out;
  logic [3:0] eff_ref;
  logic wr_go;
  logic mapped;
  logic locked;

  assign mapped = (PADDR == MODE_OFFSET) || (PADDR == ENABLE_OFFSET)
                  || (PADDR == CONTROL_OFFSET);
  assign wr_go = PSEL && PENABLE && PWRITE && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign locked = control_reg[LOCK_LSB +: 2] >= LOCK_POLARITY;

  always_comb begin
    is_out[0] = !CH12_IS_INPUT[0];
    is_out[1] = !CH12_IS_INPUT[1];
    is_out[2] = mode_reg[DIR_LSB +: 2] == DIR_OUTPUT;
    is_out[3] = mode_reg[CH_STRIDE + DIR_LSB +: 2] == DIR_OUTPUT;
  end

  // Protected fields keep their old value; the bus sees no error.
  always_comb begin
    next_mode = PWDATA[15:0];
    if (enable_reg[2*EN_STRIDE + EN_BIT]) begin
      next_mode[DIR_LSB +: 2] = mode_reg[DIR_LSB +: 2];
    end
    if (enable_reg[3*EN_STRIDE + EN_BIT]) begin
      next_mode[CH_STRIDE + DIR_LSB +: 2] =
        mode_reg[CH_STRIDE + DIR_LSB +: 2];
    end
  end

  always_comb begin
    next_enable = PWDATA[15:0];
    for (int i = 0; i < 4; i++) begin
      if (locked) begin
        next_enable[i*EN_STRIDE + POL_BIT] =
          enable_reg[i*EN_STRIDE + POL_BIT];
      end
      if (locked && is_out[i]) begin
        next_enable[i*EN_STRIDE + NPOL_BIT] =
          enable_reg[i*EN_STRIDE + NPOL_BIT];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg <= MODE_RESET;
    end else if (wr_go && PADDR == MODE_OFFSET) begin
      mode_reg <= next_mode;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_go && PADDR == ENABLE_OFFSET) begin
      enable_reg <= next_enable;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      control_reg <= CONTROL_RESET;
    end else if (wr_go && PADDR == CONTROL_OFFSET) begin
      control_reg <= PWDATA[15:0];
    end
  end

  always_comb begin
    case (PADDR)
      MODE_OFFSET: rd_word = mode_reg;
      ENABLE_OFFSET: rd_word = enable_reg;
      CONTROL_OFFSET: rd_word = control_reg;
      default: rd_word = 16'h0000;
    endcase
  end

  // Read data is caught in the setup cycle so it comes from a flop
  // without costing a wait state.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {16'h0000, rd_word};
    end
  end

  // Fields are exported only in the role the direction gives them.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CH34_CFG <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        CH34_CFG[c] <= '0;
        CH34_CFG[c].dir <= dir_e'(mode_reg[c*CH_STRIDE + DIR_LSB +: 2]);
        if (is_out[c+2]) begin
          CH34_CFG[c].ref_clear_en <= mode_reg[c*CH_STRIDE + CLR_BIT];
          CH34_CFG[c].compare_mode <=
            cmp_mode_e'(mode_reg[c*CH_STRIDE + CMP_LSB +: 3]);
          CH34_CFG[c].preload_en <= mode_reg[c*CH_STRIDE + PRE_BIT];
          CH34_CFG[c].fast_en <= mode_reg[c*CH_STRIDE + FAST_BIT];
        end else begin
          CH34_CFG[c].input_filter <= mode_reg[c*CH_STRIDE + FILT_LSB +: 4];
          CH34_CFG[c].capture_prescale <=
            mode_reg[c*CH_STRIDE + PSC_LSB +: 2];
        end
      end
    end
  end

  // The trigger mapping yields a quiet input unless the slave logic
  // really routes an internal source; a stale trigger is worse than none.
  always_comb begin
    case (dir_e'(mode_reg[DIR_LSB +: 2]))
      DIR_IN_OWN: sel_in[0] = TIMER_INPUT_3;
      DIR_IN_CROSS: sel_in[0] = TIMER_INPUT_4;
      DIR_IN_TRIG: sel_in[0] = INTERNAL_TRIGGER_SIG
                               && TRIGGER_SOURCE_INTERNAL;
      default: sel_in[0] = 1'b0;
    endcase
    case (dir_e'(mode_reg[CH_STRIDE + DIR_LSB +: 2]))
      DIR_IN_OWN: sel_in[1] = TIMER_INPUT_4;
      DIR_IN_CROSS: sel_in[1] = TIMER_INPUT_3;
      DIR_IN_TRIG: sel_in[1] = INTERNAL_TRIGGER_SIG
                               && TRIGGER_SOURCE_INTERNAL;
      default: sel_in[1] = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prev_in <= 2'b00;
    end else begin
      prev_in <= sel_in;
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      edge_hit[c] = enable_reg[(c+2)*EN_STRIDE + POL_BIT]
                    ? (prev_in[c] && !sel_in[c])
                    : (!prev_in[c] && sel_in[c]);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      psc_count[0] <= PSC_RESET;
      psc_count[1] <= PSC_RESET;
      CAPTURE <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        CAPTURE[c] <= 1'b0;
        if (!enable_reg[(c+2)*EN_STRIDE + EN_BIT] || is_out[c+2]) begin
          psc_count[c] <= PSC_RESET;
        end else if (edge_hit[c]) begin
          if (psc_count[c] == 3'((4'h1 <<
              mode_reg[c*CH_STRIDE + PSC_LSB +: 2]) - 4'h1)) begin
            psc_count[c] <= PSC_RESET;
            CAPTURE[c] <= 1'b1;
          end else begin
            psc_count[c] <= psc_count[c] + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CAPTURE_EN <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        CAPTURE_EN[i] <= !is_out[i] && enable_reg[i*EN_STRIDE + EN_BIT];
      end
    end
  end

  always_comb begin
    eff_ref[1:0] = COMPARE_REFERENCE[1:0];
    for (int c = 0; c < 2; c++) begin
      eff_ref[c+2] = COMPARE_REFERENCE[c+2] && !(FILTERED_EXT_TRIGGER
                     && mode_reg[c*CH_STRIDE + CLR_BIT]);
    end
  end

  // Dead-time insertion lives downstream; here both outputs switch together.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PINS <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic e;
        logic ne;
        logic p;
        logic np;
        e = enable_reg[i*EN_STRIDE + EN_BIT];
        ne = enable_reg[i*EN_STRIDE + NEN_BIT];
        p = enable_reg[i*EN_STRIDE + POL_BIT];
        np = enable_reg[i*EN_STRIDE + NPOL_BIT];
        if (!is_out[i]) begin
          PINS[i] <= '0;
        end else if (control_reg[MOE_BIT]) begin
          PINS[i].oc_en <= e || (control_reg[RUN_OFFSTATE_SEL_BIT] && ne);
          PINS[i].oc <= e ? (eff_ref[i] ^ p)
                      : (control_reg[RUN_OFFSTATE_SEL_BIT] && p);
          PINS[i].ocn_en <= ne || (control_reg[RUN_OFFSTATE_SEL_BIT] && e);
          PINS[i].ocn <= ne ? ((eff_ref[i] ^ e) ^ np)
                       : (control_reg[RUN_OFFSTATE_SEL_BIT] && np);
        end else begin
          PINS[i].oc_en <= control_reg[IDLE_OFFSTATE_SEL_BIT] && (e || ne);
          PINS[i].ocn_en <= control_reg[IDLE_OFFSTATE_SEL_BIT] && (e || ne);
          PINS[i].oc <= (e || ne) ? control_reg[IDLE_MAIN_LSB + i] : p;
          PINS[i].ocn <= (e || ne) ? control_reg[IDLE_COMPL_LSB + i] : np;
        end
      end
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  AST_CH4_DIR_HELD: assert property (
    enable_reg[3*EN_STRIDE + EN_BIT] |=>
      $stable(mode_reg[CH_STRIDE + DIR_LSB +: 2]))
    else $error("channel 4 direction changed while on");
  AST_CH3_DIR_HELD: assert property (
    enable_reg[2*EN_STRIDE + EN_BIT] |=> $stable(mode_reg[DIR_LSB +: 2]))
    else $error("channel 3 direction changed while on");
  AST_POL_LOCKED: assert property (
    locked && wr_go && PADDR == ENABLE_OFFSET |=>
      $stable(enable_reg[POL_BIT]) && $stable(enable_reg[EN_STRIDE+POL_BIT]))
    else $error("polarity changed under lock");
  AST_NPOL_LOCKED: assert property (
    locked && is_out[3] |=> $stable(enable_reg[3*EN_STRIDE + NPOL_BIT]))
    else $error("complementary polarity changed under lock");
  AST_CAPTURE_GATED: assert property (
    CAPTURE[0] |-> $past(enable_reg[2*EN_STRIDE + EN_BIT]) && $past(!is_out[2]))
    else $error("capture while disabled");
  AST_PSC_CLEARED: assert property (
    !enable_reg[3*EN_STRIDE + EN_BIT] |=> psc_count[1] == PSC_RESET && !CAPTURE[1])
    else $error("prescaler not cleared on disable");
  AST_REF_CLEARED: assert property (
    is_out[2] && control_reg[MOE_BIT] && enable_reg[2*EN_STRIDE + EN_BIT]
    && mode_reg[CLR_BIT] && FILTERED_EXT_TRIGGER
    |=> PINS[2].oc == $past(enable_reg[2*EN_STRIDE + POL_BIT]))
    else $error("reference not cleared by external trigger");
  AST_OC_FOLLOWS: assert property (
    is_out[0] && control_reg[MOE_BIT] && enable_reg[EN_BIT]
    |=> PINS[0].oc_en && PINS[0].oc == ($past(COMPARE_REFERENCE[0])
        ^ $past(enable_reg[POL_BIT])))
    else $error("compare output not driven");
  AST_COMPL_OFF: assert property (
    is_out[1] && control_reg[MOE_BIT] && !control_reg[RUN_OFFSTATE_SEL_BIT]
    && !enable_reg[EN_STRIDE + NEN_BIT] |=> !PINS[1].ocn_en)
    else $error("complementary output on while disabled");
  AST_TRIG_QUIET: assert property (
    mode_reg[DIR_LSB +: 2] == DIR_IN_TRIG && !TRIGGER_SOURCE_INTERNAL
    |-> !sel_in[0])
    else $error("trigger mapping active without internal source");

  COV_CAPTURE_DIV8: cover property (
    mode_reg[PSC_LSB +: 2] == 2'b11 && CAPTURE[0]);
  COV_LOCK_BLOCK: cover property (
    locked && wr_go && PADDR == ENABLE_OFFSET);
  COV_BOTH_OUTPUTS: cover property (
    PINS[3].oc_en && PINS[3].ocn_en && control_reg[MOE_BIT]);
endmodule : timer_channel_mode_enable_ctrl

`default_nettype wire

// ==== testbench/timer_channel_mode_enable_ctrl_tb_top.sv ====
// Testbench for the timer channel mode and enable control block.
// Assumes an APB slave on a 20 MHz clock and a pin-side toggle model.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_enable_ctrl_tb_top
  import timer_chan_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, ti3, ti4, trig, busy;
  logic trig_int = 1'b0;
  logic ext = 1'b0;
  logic req = 1'b0;
  logic cap_clr = 1'b0;
  logic [1:0] ch12 = 2'b00;
  logic [1:0] sel = 2'b00;
  logic [4:0] tog = 5'h0;
  logic [3:0] cref = 4'h0;
  logic [3:0] cap_en;
  logic [1:0] capture;
  logic [7:0] cnt3, cnt4;
  pin_s [3:0] pins;
  chan_cfg_s [1:0] cfg;
  int bad_count = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (cap_clr) begin
      cnt3 <= 8'h0;
      cnt4 <= 8'h0;
    end else begin
      cnt3 <= cnt3 + {7'h0, capture[0] === 1'b1};
      cnt4 <= cnt4 + {7'h0, capture[1] === 1'b1};
    end
  end

  timer_channel_mode_enable_ctrl timer_channel_mode_enable_ctrl_inst (
    .CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TIMER_INPUT_3(ti3),
    .TIMER_INPUT_4(ti4), .INTERNAL_TRIGGER_SIG(trig),
    .TRIGGER_SOURCE_INTERNAL(trig_int), .FILTERED_EXT_TRIGGER(ext),
    .CH12_IS_INPUT(ch12), .COMPARE_REFERENCE(cref), .PINS(pins),
    .CH34_CFG(cfg), .CAPTURE_EN(cap_en), .CAPTURE(capture)
  );

  timer_pin_side_model timer_pin_side_model_inst (
    .clk(clk), .rstn(rstn), .req(req), .sel(sel), .toggles(tog),
    .ti3(ti3), .ti4(ti4), .trig(trig), .busy(busy)
  );

  task stop_test;
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The master holds every request signal until pready is seen high.
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [15:0] d);
    apb(a, 1'b1, {16'h0, d});
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check(rd, e);
  endtask : rdc

  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask : do_reset

  task run_cap(input logic [15:0] mode, input logic [15:0] en,
               input logic [1:0] s, input logic t, input logic [4:0] n,
               input logic [7:0] e3, input logic [7:0] e4);
    int k;
    wr(8'h20, 16'h0);
    wr(8'h1c, mode);
    trig_int <= t;
    wr(8'h20, en);
    cap_clr <= 1'b1;
    sel <= s;
    tog <= n;
    @(posedge clk);
    cap_clr <= 1'b0;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    // Busy is looked at mid-cycle, away from the edge that updates it.
    do begin
      @(negedge clk);
      k++;
    end while (busy === 1'b1 && k < 200);
    if (busy === 1'b1) begin
      bad_count++;
      stop_test();
    end
    settle;
    settle;
    check({16'h0, cnt4, cnt3}, {16'h0, e4, e3});
    check({28'h0, cap_en}, {28'h0, mode[9:8] != 2'b00 && en[12],
          mode[1:0] != 2'b00 && en[8], 2'b00});
  endtask : run_cap

  initial begin
    int k;
    logic [3:0] ep;
    logic [2:0] m;
    logic r;
    do_reset;
    rdc(8'h1c, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h30, 32'h0);
    apb(8'h24, 1'b0, 32'h0);
    check({31'h0, er}, 32'h1);
    for (k = 0; k < 8; k++) begin
      m = k[2:0];
      wr(8'h1c, {2{1'b1, m, m[0], 1'b1, 2'b00}});
      settle;
      check({18'h0, cfg[0]}, {20'h0, 1'b1, m, m[0], 1'b1, 6'h0});
      check({18'h0, cfg[1]}, {20'h0, 1'b1, m, m[0], 1'b1, 6'h0});
    end
    // Direction bits must hold while the channel is on; others still land.
    wr(8'h20, 16'h1100);
    wr(8'h1c, 16'hf1f1);
    rdc(8'h1c, 32'hf0f0);
    wr(8'h20, 16'h0);
    wr(8'h1c, 16'hf1f1);
    rdc(8'h1c, 32'hf1f1);
    settle;
    check({18'h0, cfg[0]}, {18'h0, 2'b01, 6'h0, 4'hf, 2'b00});
    check({18'h0, cfg[1]}, {18'h0, 2'b01, 6'h0, 4'hf, 2'b00});
    wr(8'h1c, 16'h0);
    wr(8'h30, 16'h0004);
    for (k = 0; k < 32; k++) begin
      ep = k[3:0];
      r = k[4];
      wr(8'h20, {12'h0, ep});
      cref <= {3'b000, r};
      settle;
      check({28'h0, pins[0]}, {28'h0, ep[0] & (r ^ ep[1]), ep[0],
            ep[2] & (r ^ ep[0] ^ ep[3]), ep[2]});
    end
    wr(8'h30, 16'h0108);
    wr(8'h20, 16'h0001);
    settle;
    check({28'h0, pins[0]}, 32'hd);
    wr(8'h30, 16'h0004);
    wr(8'h1c, 16'h0080);
    wr(8'h20, 16'h0100);
    cref <= 4'h4;
    settle;
    check({31'h0, pins[2].oc}, 32'h1);
    @(posedge clk);
    ext <= 1'b1;
    settle;
    check({31'h0, pins[2].oc}, 32'h0);
    @(posedge clk);
    ext <= 1'b0;
    run_cap(16'h0001, 16'h0100, 2'd0, 1'b0, 5'd16, 8'd8, 8'd0);
    run_cap(16'h0005, 16'h0100, 2'd0, 1'b0, 5'd16, 8'd4, 8'd0);
    run_cap(16'h0009, 16'h0100, 2'd0, 1'b0, 5'd16, 8'd2, 8'd0);
    run_cap(16'h000d, 16'h0100, 2'd0, 1'b0, 5'd16, 8'd1, 8'd0);
    run_cap(16'h0002, 16'h0100, 2'd1, 1'b0, 5'd16, 8'd8, 8'd0);
    run_cap(16'h0001, 16'h0100, 2'd1, 1'b0, 5'd16, 8'd0, 8'd0);
    run_cap(16'h0003, 16'h0100, 2'd2, 1'b1, 5'd16, 8'd8, 8'd0);
    run_cap(16'h0003, 16'h0100, 2'd2, 1'b0, 5'd16, 8'd0, 8'd0);
    run_cap(16'h0001, 16'h0000, 2'd0, 1'b0, 5'd16, 8'd0, 8'd0);
    run_cap(16'h0001, 16'h0300, 2'd0, 1'b0, 5'd7, 8'd3, 8'd0);
    run_cap(16'h0001, 16'h0000, 2'd0, 1'b0, 5'd1, 8'd0, 8'd0);
    run_cap(16'h0100, 16'h1000, 2'd1, 1'b0, 5'd16, 8'd0, 8'd8);
    run_cap(16'h0200, 16'h1000, 2'd0, 1'b0, 5'd16, 8'd0, 8'd8);
    // Lock level 2 blocks polarity and output-side complementary polarity.
    do_reset;
    wr(8'h1c, 16'h0001);
    ch12 <= 2'b01;
    wr(8'h30, 16'h0002);
    wr(8'h20, 16'hffff);
    rdc(8'h20, 32'h5d5d);
    stop_test;
  end
endmodule : timer_channel_mode_enable_ctrl_tb_top
`default_nettype wire

// ==== testbench/timer_pin_side_model.sv ====
// Pin-side model that toggles one chosen timer input line on request.
// Assumes one-cycle requests synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module timer_pin_side_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic [1:0] sel,
  input wire logic [4:0] toggles,
  output logic ti3,
  output logic ti4,
  output logic trig,
  output logic busy
);
  logic [2:0] lines;
  logic [1:0] line_sel;
  logic [4:0] left;
  logic ph;
  // Two cycles per level, so a sampling edge detector sees every change.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lines <= 3'h0;
      line_sel <= 2'h0;
      left <= 5'h0;
      ph <= 1'b0;
    end else if (req && left == 5'h0) begin
      left <= toggles;
      line_sel <= sel;
      ph <= 1'b0;
    end else if (left != 5'h0) begin
      ph <= ~ph;
      if (ph) begin
        lines[line_sel] <= ~lines[line_sel];
        left <= left - 5'h1;
      end
    end
  end
  assign ti3 = lines[0];
  assign ti4 = lines[1];
  assign trig = lines[2];
  assign busy = (left != 5'h0);
endmodule : timer_pin_side_model
`default_nettype wire
